// ---- design/rom_top.sv ----
// remote shutdown, remote standby and external mode select control
// Behaviour
// - a low shutdown input lasting 100 us turns off input and output modules
// - shutdown stays latched until unit power is cycled
// - standby low 100 us turns output off within 200 ms, indicator on
// - standby key or output-on command restores prior output state, indicator off only if output was on
// - external mode with high or open select gives voltage mode
// - external mode with low or short select gives current mode
// - select input ignored unless external mode enabled from setup menu
// - external mode applies at once; reset value stays disabled
// - mode key refused with an error while external mode is enabled
`timescale 1ns/10ps
`default_nettype none
module rom_top #(
   parameter int unsigned MIN_PULSE_CYC = rom_pkg::MIN_PULSE_CYC,
   parameter int unsigned MAX_DELAY_CYC = 32'(rom_pkg::MAX_DELAY_CYC)
)
(
   // clock and reset
   input  wire logic             CLK,
   input  wire logic             RST_B,
   // remote pins, shutdown and standby active low, mode select high for voltage
   input  wire logic             STANDALONE_SHUTDOWN_INPUT_B,
   input  wire logic             MULTIUNIT_SHUTDOWN_INPUT_B,
   input  wire logic             STANDBY_INPUT_B,
   input  wire logic             MODE_SELECT_INPUT,
   // front panel and command interface, same clock
   input  wire rom_pkg::rom_ctrl_t CTRL,
   input  wire logic             MODE_VOLT_REQ,
   // outputs
   output logic                  POWER_MODULES_ON,
   output logic                  OUTPUT_ON,
   output logic                  STANDBY_LED,
   output logic                  VOLTAGE_MODE,
   output logic                  EXT_MODE_ERROR
);
   localparam int DW = $clog2(MAX_DELAY_CYC + 1);

   logic               sd_a_hit;
   logic               sd_b_hit;
   logic               sb_hit;
   logic               sb_lvl;
   logic               sel_lvl;
   logic               sel_s1;
   logic               sel_s2;
   logic               ext_mode;
   logic               prev_on;
   logic [DW-1:0]      dly;
   rom_pkg::rom_state_t state;

   rom_qual #(.MIN_CYC(MIN_PULSE_CYC)) u_sd_a
   (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin_b (STANDALONE_SHUTDOWN_INPUT_B),
      .lvl   (),
      .hit   (sd_a_hit)
   );
   rom_qual #(.MIN_CYC(MIN_PULSE_CYC)) u_sd_b
   (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin_b (MULTIUNIT_SHUTDOWN_INPUT_B),
      .lvl   (),
      .hit   (sd_b_hit)
   );
   rom_qual #(.MIN_CYC(MIN_PULSE_CYC)) u_sb
   (
      .clk   (CLK),
      .rst_b (RST_B),
      .pin_b (STANDBY_INPUT_B),
      .lvl   (sb_lvl),
      .hit   (sb_hit)
   );

   // mode select pin sync; open pin reads high through its pull-up
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         sel_s1 <= 1'b1;
         sel_s2 <= 1'b1;
      end
      else
      begin
         sel_s1 <= MODE_SELECT_INPUT;
         sel_s2 <= sel_s1;
      end
   end
   assign sel_lvl = sel_s2;

   // shutdown latch: only power-on reset clears it
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         POWER_MODULES_ON <= 1'b1;
      else if (sd_a_hit || sd_b_hit)
         POWER_MODULES_ON <= 1'b0;
   end

   // external mode enable; reset default stays off, recall re-applies it
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         ext_mode <= rom_pkg::RST_EXT_MODE;
      else if (CTRL.ext_mode_apply)
         ext_mode <= CTRL.ext_mode_value;
   end

   // regulation mode
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         VOLTAGE_MODE <= 1'b1;
      else if (ext_mode)
         VOLTAGE_MODE <= sel_lvl;
      else if (CTRL.key_mode)
         VOLTAGE_MODE <= MODE_VOLT_REQ;
   end

   // mode key refusal flag, one pulse per refused press
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
         EXT_MODE_ERROR <= 1'b0;
      else
         EXT_MODE_ERROR <= ext_mode && CTRL.key_mode;
   end

   // standby sequencing; the wait is short of the bound, one cycle suffices
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         state   <= rom_pkg::ROM_RUN;
         dly     <= '0;
         prev_on <= rom_pkg::RST_OUTPUT_ON;
      end
      else
      begin
         unique case (state)
            rom_pkg::ROM_RUN:
            begin
               if (sb_hit)
               begin
                  state   <= rom_pkg::ROM_STBY_WAIT;
                  prev_on <= OUTPUT_ON;
                  dly     <= '0;
               end
            end
            rom_pkg::ROM_STBY_WAIT:
            begin
               state <= rom_pkg::ROM_STBY;
               dly   <= dly + DW'(1);
            end
            rom_pkg::ROM_STBY:
            begin
               if (CTRL.key_standby || CTRL.cmd_output_on)
                  state <= rom_pkg::ROM_RUN;
            end
            default:
               state <= rom_pkg::ROM_RUN;
         endcase
      end
   end

   // output on/off and standby indicator
   always_ff @(posedge CLK)
   begin
      if (!RST_B)
      begin
         OUTPUT_ON   <= rom_pkg::RST_OUTPUT_ON;
         STANDBY_LED <= 1'b1;
      end
      else if (!POWER_MODULES_ON || sd_a_hit || sd_b_hit)
      begin
         OUTPUT_ON   <= 1'b0;
         STANDBY_LED <= 1'b1;
      end
      else if (state == rom_pkg::ROM_STBY_WAIT)
      begin
         OUTPUT_ON   <= 1'b0;
         STANDBY_LED <= 1'b1;
      end
      else if (state == rom_pkg::ROM_STBY)
      begin
         if (CTRL.key_standby || CTRL.cmd_output_on)
         begin
            OUTPUT_ON   <= prev_on;
            STANDBY_LED <= !prev_on;
         end
      end
      else if (!sb_hit)
      begin
         if (CTRL.cmd_output_on)
         begin
            OUTPUT_ON   <= 1'b1;
            STANDBY_LED <= 1'b0;
         end
         else if (CTRL.key_standby)
         begin
            OUTPUT_ON   <= !OUTPUT_ON;
            STANDBY_LED <= OUTPUT_ON;
         end
      end
   end

   // standby request reaches output off well inside the bound
   sequence s_stby_req;
      sb_hit && POWER_MODULES_ON && state == rom_pkg::ROM_RUN;
   endsequence
   sequence s_out_off;
      !OUTPUT_ON && STANDBY_LED;
   endsequence

   AST_STBY_OFF: assert property (@(posedge CLK) disable iff (!RST_B)
      s_stby_req |-> ##[1:3] s_out_off)
      else $error("standby request did not turn output off");

   AST_SD_LATCH: assert property (@(posedge CLK) disable iff (!RST_B)
      !POWER_MODULES_ON |=> !POWER_MODULES_ON)
      else $error("shutdown latch released without power cycle");

   AST_SD_OFF: assert property (@(posedge CLK) disable iff (!RST_B)
      (sd_a_hit || sd_b_hit) |=> !POWER_MODULES_ON && !OUTPUT_ON)
      else $error("qualified shutdown did not stop power transfer");

   AST_SD_OUT: assert property (@(posedge CLK) disable iff (!RST_B)
      !POWER_MODULES_ON |=> !OUTPUT_ON)
      else $error("output on while shut down");

   AST_EXT_SEL: assert property (@(posedge CLK) disable iff (!RST_B)
      ext_mode && $stable(ext_mode) |=> VOLTAGE_MODE == $past(sel_lvl))
      else $error("mode does not follow select input");

   AST_NO_EXT: assert property (@(posedge CLK) disable iff (!RST_B)
      !ext_mode && !CTRL.key_mode |=> $stable(VOLTAGE_MODE))
      else $error("mode changed without external mode or key");

   AST_MODE_ERR: assert property (@(posedge CLK) disable iff (!RST_B)
      ext_mode && CTRL.key_mode |=> EXT_MODE_ERROR)
      else $error("mode key not refused under external mode");

   AST_RESTORE: assert property (@(posedge CLK) disable iff (!RST_B)
      state == rom_pkg::ROM_STBY && POWER_MODULES_ON && CTRL.cmd_output_on
      && !sd_a_hit && !sd_b_hit
      |=> OUTPUT_ON == $past(prev_on) && STANDBY_LED == !$past(prev_on))
      else $error("standby exit did not restore prior state");

   // a pulse of exactly the minimum width may already be released when hit shows
   AST_QUAL: assert property (@(posedge CLK) disable iff (!RST_B)
      sb_hit |-> $past(!sb_lvl) && $past(!sb_lvl, 2))
      else $error("standby accepted without qualified low");

   AST_STBY_DLY: assert property (@(posedge CLK) disable iff (!RST_B)
      state == rom_pkg::ROM_STBY_WAIT |-> dly < DW'(MAX_DELAY_CYC))
      else $error("standby wait exceeded the delay bound");
endmodule
`default_nettype wire

// ---- design/rom_pkg.sv ----
// package for the remote output and mode control block
package rom_pkg;
   localparam int unsigned CLK_HZ        = 50_000_000;
   localparam int unsigned MIN_PULSE_NS  = 100_000;
   localparam int unsigned MAX_DELAY_MS  = 200;
   // least time rounds up
   localparam int unsigned MIN_PULSE_CYC =
      (MIN_PULSE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   // longest time rounds down
   localparam longint unsigned MAX_DELAY_CYC =
      longint'(MAX_DELAY_MS) * longint'(CLK_HZ) / 64'd1000;
   localparam logic RST_OUTPUT_ON = 1'b0;
   localparam logic RST_EXT_MODE  = 1'b0;

   typedef enum logic [1:0]
   {
      ROM_RUN      = 2'b00,
      ROM_STBY_WAIT = 2'b01,
      ROM_STBY     = 2'b10
   } rom_state_t;

   typedef struct packed
   {
      logic key_standby;
      logic cmd_output_on;
      logic key_mode;
      logic ext_mode_apply;
      logic ext_mode_value;
   } rom_ctrl_t;
endpackage

// ---- design/rom_qual.sv ----
// synchroniser plus minimum pulse width qualifier for an active-low pin
`timescale 1ns/10ps
`default_nettype none
module rom_qual #(
   parameter int unsigned MIN_CYC = 5000
)
(
   // clock and reset
   input  wire logic clk,
   input  wire logic rst_b,
   // pin and result
   input  wire logic pin_b,
   output logic      lvl,
   output logic      hit
);
   localparam int W = $clog2(MIN_CYC + 1);
   logic         s1;
   logic         s2;
   logic [W-1:0] cnt;

   always_ff @(posedge clk)
   begin
      if (!rst_b)
      begin
         s1 <= 1'b1;
         s2 <= 1'b1;
      end
      else
      begin
         s1 <= pin_b;
         s2 <= s1;
      end
   end

   assign lvl = s2;

   // one pulse once the low level has lasted the minimum width
   always_ff @(posedge clk)
   begin
      if (!rst_b || s2)
      begin
         cnt <= '0;
         hit <= 1'b0;
      end
      else if (cnt != W'(MIN_CYC))
      begin
         cnt <= cnt + W'(1);
         hit <= (cnt == W'(MIN_CYC - 1));
      end
      else
         hit <= 1'b0;
   end
endmodule
`default_nettype wire

// ---- verification/rom_far_ctl.sv ----
// far-side controller model driving the remote pins
`timescale 1ns/10ps
`default_nettype none
module rom_far_ctl
(
   // clock
   input  wire logic clk,
   // remote pins
   output logic      shut_sa_b,
   output logic      shut_mu_b,
   output logic      stby_b,
   output logic      mode_sel
);
   // released pins sit at the pull-up level
   initial
   begin
      shut_sa_b = 1'b1;
      shut_mu_b = 1'b1;
      stby_b    = 1'b1;
      mode_sel  = 1'b1;
   end
   // which: 0 standalone shutdown, 1 master shutdown port, 2 standby
   task automatic pull_low(input int which, input int cyc);
   begin
      @(negedge clk);
      case (which)
         0: shut_sa_b = 1'b0;
         1: shut_mu_b = 1'b0;
         default: stby_b = 1'b0;
      endcase
      repeat (cyc) @(negedge clk);
      shut_sa_b = 1'b1;
      shut_mu_b = 1'b1;
      stby_b    = 1'b1;
   end
   endtask
endmodule
`default_nettype wire

// ---- verification/tb_rom_top.sv ----
// self-checking bench for the remote output and mode control block
`timescale 1ns/10ps
`default_nettype none
module tb_rom_top;
   // short qualifier keeps the run brief
   localparam int unsigned N = 8;
   logic               clk, rst_b, sa_b, mu_b, sb_b, msel, volt_req;
   logic               pwr, outp, led, volt, err;
   rom_pkg::rom_ctrl_t ctrl;
   int                 miscompares, n_compared, i, j;
   logic               e_pwr, e_out, e_volt;

   rom_top #(.MIN_PULSE_CYC(N)) rom_top_inst (.CLK(clk), .RST_B(rst_b),
      .STANDALONE_SHUTDOWN_INPUT_B(sa_b), .MULTIUNIT_SHUTDOWN_INPUT_B(mu_b),
      .STANDBY_INPUT_B(sb_b), .MODE_SELECT_INPUT(msel), .CTRL(ctrl),
      .MODE_VOLT_REQ(volt_req), .POWER_MODULES_ON(pwr), .OUTPUT_ON(outp),
      .STANDBY_LED(led), .VOLTAGE_MODE(volt), .EXT_MODE_ERROR(err));
   rom_far_ctl rom_far_ctl_inst (.clk(clk), .shut_sa_b(sa_b), .shut_mu_b(mu_b),
      .stby_b(sb_b), .mode_sel(msel));

   initial
   begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end

   task automatic chk(input logic seen, input logic exp);
   begin
      n_compared++;
      if (seen !== exp)
      begin
         miscompares++;
         $display("CHECK FAILED %0t output differs from model", $time);
      end
   end
   endtask

   task automatic chk_all;
   begin
      chk(pwr, e_pwr);
      chk(outp, e_out);
      if (e_pwr)
         chk(led, !e_out);
      chk(volt, e_volt);
      chk(err, 1'b0);
   end
   endtask

   task automatic hit(input rom_pkg::rom_ctrl_t c);
   begin
      @(negedge clk);
      ctrl = c;
      @(negedge clk);
      ctrl = 5'h00;
   end
   endtask

   task automatic reset_dut;
   begin
      @(negedge clk);
      rst_b = 1'b0;
      repeat (5) @(negedge clk);
      rst_b = 1'b1;
      e_pwr = 1'b1;
      e_out = 1'b0;
      e_volt = 1'b1;
   end
   endtask

   task automatic summarize;
   begin
      if (miscompares == 0 && n_compared > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   end
   endtask

   initial
   begin
      rst_b = 1'b0;
      ctrl = 5'h00;
      volt_req = 1'b1;
      miscompares = 0;
      n_compared = 0;
      i = $urandom(57622);
      reset_dut;
      chk_all;
      rom_far_ctl_inst.mode_sel = 1'b0;
      repeat (6) @(negedge clk);
      chk_all;
      hit(5'h08);
      e_out = 1'b1;
      chk_all;
      rom_far_ctl_inst.pull_low(2, N - 2);
      repeat (6) @(negedge clk);
      chk_all;
      for (i = 0; i < 2; i++)
      begin
         rom_far_ctl_inst.pull_low(2, N + 1);
         repeat (5) @(negedge clk);
         e_out = 1'b0;
         chk_all;
         hit(i[0] ? 5'h08 : 5'h10);
         e_out = 1'b1;
         chk_all;
      end
      // local standby key toggles; remote standby while off restores off
      hit(5'h10);
      e_out = 1'b0;
      chk_all;
      rom_far_ctl_inst.pull_low(2, N + 1);
      repeat (5) @(negedge clk);
      chk_all;
      hit(5'h08);
      chk_all;
      hit(5'h10);
      e_out = 1'b1;
      chk_all;
      for (i = 0; i < 4; i++)
      begin
         volt_req = 1'($urandom);
         hit(5'h04);
         e_volt = volt_req;
         chk_all;
      end
      hit(5'h03);
      for (i = 0; i < 6; i++)
      begin
         rom_far_ctl_inst.mode_sel = i[0];
         repeat (6) @(negedge clk);
         e_volt = i[0];
         chk_all;
      end
      volt_req = !e_volt;
      hit(5'h04);
      chk(err, 1'b1);
      @(negedge clk);
      chk_all;
      hit(5'h02);
      rom_far_ctl_inst.mode_sel = !e_volt;
      repeat (6) @(negedge clk);
      chk_all;
      for (j = 0; j < 2; j++)
      begin
         rom_far_ctl_inst.pull_low(j, N - 2);
         repeat (6) @(negedge clk);
         chk_all;
         rom_far_ctl_inst.pull_low(j, N + 1);
         repeat (5) @(negedge clk);
         e_pwr = 1'b0;
         e_out = 1'b0;
         chk_all;
         hit(5'h08);
         chk_all;
         reset_dut;
         rom_far_ctl_inst.mode_sel = 1'b0;
         repeat (6) @(negedge clk);
         chk_all;
         hit(5'h08);
         e_out = 1'b1;
         chk_all;
      end
      summarize;
   end
endmodule
`default_nettype wire
